// ### src/pcm_channel_ctrl.v
// Channel-mode control: load mode, pair swap, masking and layered write protection
`timescale 1ns/1ps
`include "pcm_defines.vh"
module pcm_channel_ctrl (
  input  wire                               i_mclk,
  input  wire                               i_rst,
  // Avalon-MM slave, byte address
  input  wire [15:0]                        i_avs_address,
  input  wire                               i_avs_read,
  input  wire                               i_avs_write,
  input  wire [3:0]                         i_avs_byteenable,
  input  wire [31:0]                        i_avs_writedata,
  output reg  [31:0]                        o_avs_readdata,
  output wire                               o_avs_waitrequest,
  // Raw generator outputs, one per channel
  input  wire [`PCM_NUM_CH-1:0]             i_pwm_raw,
  // Conditioned channel outputs
  output reg  [`PCM_NUM_CH-1:0]             o_pwm,
  // Compare values for the generator
  output wire [`PCM_NUM_CH*`PCM_VAL_W-1:0]  o_vals,
  // Control state seen by the generator
  output wire [1:0]                         o_value_load_mode,
  output wire [2:0]                         o_swap_pairs,
  output wire [`PCM_NUM_CH-1:0]             o_channel_mask_bits,
  output wire                               o_accel_write_enable,
  output wire                               o_write_lock
);

  // Decode a byte address into a word index
  function [13:0] pcm_index;
    input [15:0] addr;
    begin
      pcm_index = addr[15:2];
    end
  endfunction

  // True when the word index hits a given register
  function pcm_hit;
    input [15:0] addr;
    input [15:0] idx;
    begin
      pcm_hit = (pcm_index(addr) == idx[13:0]);
    end
  endfunction

  // True for an accepted write with lane zero enabled on a hit register
  function pcm_lane0_write;
    input       fire;
    input       hit;
    input [3:0] be;
    begin
      pcm_lane0_write = fire & hit & be[0];
    end
  endfunction

  // Stored control fields
  reg [1:0]             value_load_mode;
  reg                   swap_pair_four_five;
  reg                   swap_pair_two_three;
  reg                   swap_pair_zero_one;
  reg                   accel_write_enable;
  reg [`PCM_NUM_CH-1:0] channel_mask_bits;
  reg                   cfg_lock;
  reg [2:0]             cfg_indep;

  // Bus handshake state
  reg [1:0]             phase;
  reg [1:0]             next_phase;
  wire                  req;
  wire                  wr_fire;
  wire                  rd_load;

  // Address decode
  wire                  hit_cfg;
  wire                  hit_low;
  wire                  hit_high;
  wire                  hit_val;
  wire [13:0]           val_off;
  wire [2:0]            val_sel;

  // Value memory connections
  reg  [`PCM_NUM_CH-1:0] val_we;
  wire [`PCM_VAL_W-1:0]  val_rdata;

  // Register images for read back
  wire [7:0]            low_image;
  wire [7:0]            high_image;
  wire [7:0]            cfg_image;
  reg  [31:0]           next_readdata;

  // Output conditioning
  reg  [`PCM_NUM_CH-1:0] next_pwm;
  wire [2:0]            swap_vec;
  integer               p;

  // Sized reset images and value base
  wire [7:0]            low_reset;
  wire [7:0]            high_reset;
  wire [7:0]            cfg_reset;
  wire [15:0]           val_base;

  // Lane-zero writes reaching each byte register
  wire                  wr_cfg;
  wire                  wr_low;
  wire                  wr_high;

  // Next values of the stored fields
  reg  [1:0]             next_value_load_mode;
  reg                    next_swap_pair_four_five;
  reg                    next_swap_pair_two_three;
  reg                    next_swap_pair_zero_one;
  reg                    next_accel_write_enable;
  reg  [`PCM_NUM_CH-1:0] next_channel_mask_bits;
  reg                    next_cfg_lock;
  reg  [2:0]             next_cfg_indep;

  // Handshake: fetch cycle, then acknowledge with waitrequest low
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & (phase != `PCM_PH_ACK);
  assign wr_fire           = i_avs_write & (phase == `PCM_PH_ACK);
  assign rd_load           = i_avs_read & (phase == `PCM_PH_FETCH);

  // Phase sequencing
  always @* begin
    case (phase)
      `PCM_PH_IDLE:  next_phase = req ? `PCM_PH_FETCH : `PCM_PH_IDLE;
      `PCM_PH_FETCH: next_phase = req ? `PCM_PH_ACK : `PCM_PH_IDLE;
      `PCM_PH_ACK:   next_phase = `PCM_PH_IDLE;
      default:       next_phase = `PCM_PH_IDLE;
    endcase
  end

  // Phase register
  always @(posedge i_mclk) begin
    if (i_rst) begin
      phase <= `PCM_PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Sized constants, so fields can be sliced out of them
  assign low_reset  = `PCM_LOW_RESET;
  assign high_reset = `PCM_HIGH_RESET;
  assign cfg_reset  = `PCM_CFG_RESET;
  assign val_base   = `PCM_IDX_VAL_BASE;

  // Register hits
  assign hit_cfg  = pcm_hit(i_avs_address, `PCM_IDX_CONFIG);
  assign hit_low  = pcm_hit(i_avs_address, `PCM_IDX_CH_LOW);
  assign hit_high = pcm_hit(i_avs_address, `PCM_IDX_CH_HIGH);
  assign val_off  = pcm_index(i_avs_address) - val_base[13:0];
  assign hit_val  = (val_off < 14'h6);
  assign val_sel  = val_off[2:0];

  // Byte register writes; lane zero carries the whole register
  assign wr_cfg  = pcm_lane0_write(wr_fire, hit_cfg, i_avs_byteenable);
  assign wr_low  = pcm_lane0_write(wr_fire, hit_low, i_avs_byteenable);
  assign wr_high = pcm_lane0_write(wr_fire, hit_high, i_avs_byteenable);

  // Compare value write enables with broadcast load modes
  always @* begin
    val_we = {`PCM_NUM_CH{1'b0}};
    if (wr_fire && hit_val) begin
      val_we[val_sel] = 1'b1;
      if (val_sel == 3'h0) begin
        case (value_load_mode)
          `PCM_MODE_ALL_SIX:   val_we = 6'h3f;
          `PCM_MODE_FIRST_FOUR: val_we = 6'h0f;
          default:             val_we = 6'h01;
        endcase
      end
    end
  end

  // Compare value storage
  pcm_value_mem u_vals (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_we    (val_we),
    .i_wbe   (i_avs_byteenable[1:0]),
    .i_wdata (i_avs_writedata[15:0]),
    .i_raddr (hit_val ? val_sel : 3'h7),
    .o_rdata (val_rdata),
    .o_vals  (o_vals)
  );

  // Configuration next value; lock is set-once until reset
  always @* begin
    next_cfg_lock  = cfg_lock;
    next_cfg_indep = cfg_indep;
    if (wr_cfg && !cfg_lock) begin
      next_cfg_lock  = i_avs_writedata[`PCM_CFG_LOCK_BIT];
      next_cfg_indep = i_avs_writedata[`PCM_CFG_INDEP_MSB:`PCM_CFG_INDEP_LSB];
    end
  end

  // Configuration register
  always @(posedge i_mclk) begin
    if (i_rst) begin
      cfg_lock  <= cfg_reset[`PCM_CFG_LOCK_BIT];
      cfg_indep <= cfg_reset[`PCM_CFG_INDEP_MSB:`PCM_CFG_INDEP_LSB];
    end else begin
      cfg_lock  <= next_cfg_lock;
      cfg_indep <= next_cfg_indep;
    end
  end

  // Low register next value; mode and swap guarded by acceleration enable
  always @* begin
    next_value_load_mode     = value_load_mode;
    next_swap_pair_four_five = swap_pair_four_five;
    next_swap_pair_two_three = swap_pair_two_three;
    next_swap_pair_zero_one  = swap_pair_zero_one;
    if (wr_low && accel_write_enable) begin
      next_value_load_mode     = i_avs_writedata[`PCM_LOW_MODE_MSB:`PCM_LOW_MODE_LSB];
      next_swap_pair_four_five = i_avs_writedata[`PCM_LOW_SWAP45_BIT];
      next_swap_pair_two_three = i_avs_writedata[`PCM_LOW_SWAP23_BIT];
      next_swap_pair_zero_one  = i_avs_writedata[`PCM_LOW_SWAP01_BIT];
    end
  end

  // Low register
  always @(posedge i_mclk) begin
    if (i_rst) begin
      value_load_mode     <= low_reset[`PCM_LOW_MODE_MSB:`PCM_LOW_MODE_LSB];
      swap_pair_four_five <= low_reset[`PCM_LOW_SWAP45_BIT];
      swap_pair_two_three <= low_reset[`PCM_LOW_SWAP23_BIT];
      swap_pair_zero_one  <= low_reset[`PCM_LOW_SWAP01_BIT];
    end else begin
      value_load_mode     <= next_value_load_mode;
      swap_pair_four_five <= next_swap_pair_four_five;
      swap_pair_two_three <= next_swap_pair_two_three;
      swap_pair_zero_one  <= next_swap_pair_zero_one;
    end
  end

  // High register next value; enable guarded by lock, mask always writable
  always @* begin
    next_accel_write_enable = accel_write_enable;
    next_channel_mask_bits  = channel_mask_bits;
    if (wr_high) begin
      if (!cfg_lock) begin
        next_accel_write_enable = i_avs_writedata[`PCM_HIGH_ACCEL_BIT];
      end
      next_channel_mask_bits = i_avs_writedata[`PCM_NUM_CH-1:0];
    end
  end

  // High register
  always @(posedge i_mclk) begin
    if (i_rst) begin
      accel_write_enable <= high_reset[`PCM_HIGH_ACCEL_BIT];
      channel_mask_bits  <= high_reset[`PCM_NUM_CH-1:0];
    end else begin
      accel_write_enable <= next_accel_write_enable;
      channel_mask_bits  <= next_channel_mask_bits;
    end
  end

  // Read images; reserved bits are constants
  assign low_image  = {2'b00, value_load_mode, 1'b0, swap_pair_four_five,
                       swap_pair_two_three, swap_pair_zero_one};
  assign high_image = {accel_write_enable, 1'b1, channel_mask_bits};
  assign cfg_image  = {4'h0, cfg_indep, cfg_lock};

  // Read data selection; unmapped addresses read zero
  always @* begin
    next_readdata = 32'h0000_0000;
    if (hit_low) begin
      next_readdata = {24'h00_0000, low_image};
    end else if (hit_high) begin
      next_readdata = {24'h00_0000, high_image};
    end else if (hit_cfg) begin
      next_readdata = {24'h00_0000, cfg_image};
    end else if (hit_val) begin
      next_readdata = {16'h0000, val_rdata};
    end
  end

  // Read data register, loaded one cycle before acknowledge
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (rd_load) begin
      o_avs_readdata <= next_readdata;
    end
  end

  // Pair swap vector, indexed by pair number
  assign swap_vec = {swap_pair_four_five, swap_pair_two_three, swap_pair_zero_one};

  // Swap and mask on each channel pair
  always @* begin
    next_pwm = i_pwm_raw;
    for (p = 0; p < 3; p = p + 1) begin
      if (!cfg_indep[p] && swap_vec[p]) begin
        // Complementary pair: swapped pair exchanges true and inverted legs
        next_pwm[2*p]   = ~i_pwm_raw[2*p];
        next_pwm[2*p+1] = i_pwm_raw[2*p];
      end else if (!cfg_indep[p]) begin
        next_pwm[2*p]   = i_pwm_raw[2*p];
        next_pwm[2*p+1] = ~i_pwm_raw[2*p];
      end
    end
    // Masked channels sit at zero duty
    next_pwm = next_pwm & ~channel_mask_bits;
  end

  // Registered channel outputs
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_pwm <= {`PCM_NUM_CH{1'b0}};
    end else begin
      o_pwm <= next_pwm;
    end
  end

  // Control state to the generator
  assign o_value_load_mode    = value_load_mode;
  assign o_swap_pairs         = swap_vec;
  assign o_channel_mask_bits  = channel_mask_bits;
  assign o_accel_write_enable = accel_write_enable;
  assign o_write_lock         = cfg_lock;

endmodule

// ### include/pcm_defines.vh
// Register map, field positions and reset values of the channel-mode control block
`ifndef PCM_DEFINES_VH
`define PCM_DEFINES_VH

// Word indexes; byte address is four times the index
`define PCM_IDX_CONFIG        16'h17e0
`define PCM_IDX_CH_LOW        16'h17e2
`define PCM_IDX_CH_HIGH       16'h17e3
`define PCM_IDX_VAL_BASE      16'h17f0
`define PCM_NUM_CH            6
`define PCM_VAL_W             16

// Low channel-control register fields
`define PCM_LOW_SWAP01_BIT    0
`define PCM_LOW_SWAP23_BIT    1
`define PCM_LOW_SWAP45_BIT    2
`define PCM_LOW_MODE_LSB      4
`define PCM_LOW_MODE_MSB      5
`define PCM_LOW_RESET         8'h00

// High channel-control register fields
`define PCM_HIGH_ACCEL_BIT    7
`define PCM_HIGH_RSVD_ONE_BIT 6
`define PCM_HIGH_RESET        8'h40

// Configuration register fields
`define PCM_CFG_LOCK_BIT      0
`define PCM_CFG_INDEP_LSB     1
`define PCM_CFG_INDEP_MSB     3
`define PCM_CFG_RESET         8'h00

// Value load modes
`define PCM_MODE_INDEP        2'h0
`define PCM_MODE_ALL_SIX      2'h1
`define PCM_MODE_FIRST_FOUR   2'h2
`define PCM_MODE_RESERVED     2'h3

// Bus handshake phases
`define PCM_PH_IDLE           2'h0
`define PCM_PH_FETCH          2'h1
`define PCM_PH_ACK            2'h2
`endif

// ### src/pcm_value_mem.v
// Six compare value registers with per-entry write enables and registered read
`timescale 1ns/1ps
`include "pcm_defines.vh"
module pcm_value_mem (
  input  wire                               i_mclk,
  input  wire                               i_rst,
  input  wire [`PCM_NUM_CH-1:0]             i_we,
  input  wire [1:0]                         i_wbe,
  input  wire [`PCM_VAL_W-1:0]              i_wdata,
  input  wire [2:0]                         i_raddr,
  output reg  [`PCM_VAL_W-1:0]              o_rdata,
  output wire [`PCM_NUM_CH*`PCM_VAL_W-1:0]  o_vals
);
  reg [`PCM_VAL_W-1:0] val_q [0:`PCM_NUM_CH-1];

  // One register per channel, byte lanes honoured
  genvar g;
  generate
    for (g = 0; g < `PCM_NUM_CH; g = g + 1) begin : g_val
      always @(posedge i_mclk) begin
        if (i_rst) begin
          val_q[g] <= {`PCM_VAL_W{1'b0}};
        end else if (i_we[g]) begin
          if (i_wbe[0]) val_q[g][7:0]  <= i_wdata[7:0];
          if (i_wbe[1]) val_q[g][15:8] <= i_wdata[15:8];
        end
      end
      assign o_vals[g*`PCM_VAL_W +: `PCM_VAL_W] = val_q[g];
    end
  endgenerate

  // Registered read port
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= {`PCM_VAL_W{1'b0}};
    end else if (i_raddr < 3'h6) begin
      o_rdata <= val_q[i_raddr];
    end else begin
      o_rdata <= {`PCM_VAL_W{1'b0}};
    end
  end
endmodule

// ### dv/pcm_chk.sv
// Port checker for the channel-mode control block
`timescale 1ns/1ps
module pcm_chk (
  input wire        i_mclk,
  input wire        i_rst,
  input wire [15:0] i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [3:0]  i_avs_byteenable,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire [5:0]  o_pwm,
  input wire [95:0] o_vals,
  input wire [1:0]  o_value_load_mode,
  input wire [2:0]  o_swap_pairs,
  input wire [5:0]  o_channel_mask_bits,
  input wire        o_accel_write_enable,
  input wire        o_write_lock
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Accepted bus cycles
  wire wr_ack = i_avs_write && !o_avs_waitrequest;
  wire rd_ack = i_avs_read && !o_avs_waitrequest;
  a_mode_hold: assert property (!o_accel_write_enable |=> $stable(o_value_load_mode))
    else $error("load mode changed while disabled");
  a_swap_hold: assert property (!o_accel_write_enable |=> $stable(o_swap_pairs))
    else $error("swap changed while disabled");
  a_enable_frozen: assert property (o_write_lock |=> $stable(o_accel_write_enable))
    else $error("enable changed while locked");
  a_wait_two: assert property ($rose(i_avs_read || i_avs_write) |->
    o_avs_waitrequest [*2] ##1 !o_avs_waitrequest) else $error("wait count wrong");
  a_low_rsvd: assert property (rd_ack && i_avs_address == 16'h5f88 |->
    o_avs_readdata[7:6] == 2'h0 && !o_avs_readdata[3]) else $error("low reserved bits set");
  a_high_one: assert property (rd_ack && i_avs_address == 16'h5f8c |-> o_avs_readdata[6])
    else $error("high reserved bit clear");
  a_mask_free: assert property (wr_ack && i_avs_address == 16'h5f8c && i_avs_byteenable[0]
    |=> o_channel_mask_bits == $past(i_avs_writedata[5:0])) else $error("mask not written");
  a_mask_zero: assert property (o_channel_mask_bits != 6'h00
    |=> (o_pwm & $past(o_channel_mask_bits)) == 6'h00) else $error("masked channel high");
  a_bcast_six: assert property (wr_ack && i_avs_address == 16'h5fc0 &&
    i_avs_byteenable[1:0] == 2'h3 && o_value_load_mode == 2'h1
    |=> o_vals == {6{$past(i_avs_writedata[15:0])}}) else $error("broadcast six wrong");
  a_bcast_four: assert property (wr_ack && i_avs_address == 16'h5fc0 &&
    i_avs_byteenable[1:0] == 2'h3 && o_value_load_mode == 2'h2
    |=> o_vals[63:0] == {4{$past(i_avs_writedata[15:0])}}) else $error("broadcast four wrong");
endmodule

bind pcm_channel_ctrl pcm_chk u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_pwm(o_pwm),
  .o_vals(o_vals), .o_value_load_mode(o_value_load_mode), .o_swap_pairs(o_swap_pairs),
  .o_channel_mask_bits(o_channel_mask_bits), .o_accel_write_enable(o_accel_write_enable),
  .o_write_lock(o_write_lock));

// ### dv/tb.sv
// Self-checking bench for the channel-mode control block
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] a_cfg = 16'h5f80, a_lo = 16'h5f88, a_hi = 16'h5f8c, a_v0 = 16'h5fc0;
  logic        i_mclk = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [15:0] i_avs_address = 16'h0000, d16;
  logic [3:0]  i_avs_byteenable = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [5:0]  i_pwm_raw = 6'h00, m, raw;
  logic [2:0]  sw, ind;
  logic [15:0] val[6];
  logic [31:0] rd_q[$];
  wire  [31:0] o_avs_readdata;
  wire         o_avs_waitrequest;
  wire  [5:0]  o_pwm;
  wire  [95:0] o_vals;
  wire  [1:0]  o_value_load_mode;
  wire  [2:0]  o_swap_pairs;
  wire  [5:0]  o_channel_mask_bits;
  wire         o_accel_write_enable, o_write_lock;
  int          mismatches = 0, compares = 0;

  // Free-running 50 MHz clock
  always #10 i_mclk = ~i_mclk;

  pcm_channel_ctrl DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_pwm_raw(i_pwm_raw), .o_pwm(o_pwm),
    .o_vals(o_vals), .o_value_load_mode(o_value_load_mode), .o_swap_pairs(o_swap_pairs),
    .o_channel_mask_bits(o_channel_mask_bits), .o_accel_write_enable(o_accel_write_enable),
    .o_write_lock(o_write_lock));

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected readdata exp %h got %h", e, g);
    end
  endtask

  task automatic chk_pwm(input logic [5:0] e, input logic [5:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected pwm exp %h got %h", e, g);
    end
  endtask

  task automatic chk_ctl(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // One bus cycle held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    // Hold until waitrequest is sampled low at a rising edge
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest && n < 20);
    if (n >= 20) mismatches++;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  function automatic logic [5:0] exp_pwm(logic [5:0] r, logic [2:0] s, logic [2:0] id,
                                         logic [5:0] mk);
    logic [5:0] o;
    for (int p = 0; p < 3; p++) begin
      o[2*p] = id[p] ? r[2*p] : r[2*p] ^ s[p];
      o[2*p+1] = id[p] ? r[2*p+1] : !(r[2*p] ^ s[p]);
    end
    return o & ~mk;
  endfunction

  // Each finished read meets the oldest expectation
  always @(negedge i_mclk) begin
    if (i_avs_read && !o_avs_waitrequest) begin
      if (rd_q.size() == 0) begin
        mismatches++;
        $display("unexpected readdata exp none got %h", o_avs_readdata);
      end else chk_rd(rd_q.pop_front(), o_avs_readdata);
    end
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    void'($urandom(36));
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(a_lo, 32'h00);
    rd(a_hi, 32'h40);
    rd(a_cfg, 32'h00);
    // Protected fields hold while acceleration is off
    m = 6'($urandom);
    bus(1'b1, a_lo, 32'hff, 4'h1);
    bus(1'b1, a_hi, {26'h0, m}, 4'h1);
    rd(a_lo, 32'h00);
    rd(a_hi, {24'h0, 2'b01, m});
    // Acceleration on; lane 0 off first, then a lane 0 write
    bus(1'b1, a_hi, {24'h0, 2'b10, m}, 4'h1);
    bus(1'b1, a_lo, 32'hff, 4'he);
    rd(a_lo, 32'h00);
    bus(1'b1, a_lo, 32'hff, 4'h1);
    rd(a_lo, 32'h37);
    rd(a_hi, {24'h0, 2'b11, m});
    // Value register broadcast per load mode
    for (int md = 0; md < 4; md++) begin
      bus(1'b1, a_lo, 32'h00, 4'h1);
      for (int k = 0; k < 6; k++) begin
        val[k] = 16'($urandom);
        bus(1'b1, a_v0 + 16'(4*k), {16'h0, val[k]}, 4'h3);
      end
      bus(1'b1, a_lo, 32'(md) << 4, 4'h1);
      d16 = 16'($urandom);
      bus(1'b1, a_v0, {16'h0, d16}, 4'h3);
      chk_ctl("load_mode", 16'(md), 16'(o_value_load_mode));
      for (int k = 0; k < 6; k++) begin
        if (k == 0 || md == 1 || (md == 2 && k < 4)) val[k] = d16;
        rd(a_v0 + 16'(4*k), {16'h0, val[k]});
        chk_ctl("value", val[k], o_vals[16*k +: 16]);
      end
    end
    // Swap and mask on complementary and independent pairs
    for (int i = 0; i < 16; i++) begin
      sw = 3'($urandom);
      ind = 3'($urandom);
      m = 6'($urandom);
      raw = 6'($urandom);
      bus(1'b1, a_lo, {29'h0, sw}, 4'h1);
      bus(1'b1, a_cfg, {28'h0, ind, 1'b0}, 4'h1);
      bus(1'b1, a_hi, {24'h0, 2'b10, m}, 4'h1);
      @(posedge i_mclk);
      i_pwm_raw <= raw;
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      chk_pwm(exp_pwm(raw, sw, ind, m), o_pwm);
      chk_ctl("swap_pairs", 16'(sw), 16'(o_swap_pairs));
      chk_ctl("mask_bits", 16'(m), 16'(o_channel_mask_bits));
    end
    // Lock freezes the enable and the config; the mask stays writable
    bus(1'b1, a_cfg, 32'h01, 4'h1);
    m = 6'($urandom);
    bus(1'b1, a_hi, {26'h0, m}, 4'h1);
    rd(a_hi, {24'h0, 2'b11, m});
    bus(1'b1, a_cfg, 32'h0e, 4'h1);
    rd(a_cfg, 32'h01);
    chk_ctl("write_lock", 16'h0001, 16'(o_write_lock));
    chk_ctl("accel_enable", 16'h0001, 16'(o_accel_write_enable));
    rd(16'h0000, 32'h0);
    // Second reset in mid-run clears the lock
    @(posedge i_mclk);
    i_rst <= 1'b1;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(a_cfg, 32'h00);
    rd(a_hi, 32'h40);
    rd(a_lo, 32'h00);
    report_and_stop();
  end
endmodule
